/* File: hw/dsjx_regs.svh */
/*
 * constants for the decrement-skip / direct-jump execution block:
 * opcode fields, operand positions, widths and reset values.
 * assumes a 12-bit instruction word and an 11-bit program counter.
 */
`ifndef DSJX_REGS_SVH
`define DSJX_REGS_SVH

`define DSJX_INSTR_W        12
`define DSJX_PC_W           11
`define DSJX_DATA_W         8
`define DSJX_FADDR_W        5
`define DSJX_DEC_OPC_HI     11
`define DSJX_DEC_OPC_LO     6
`define DSJX_DEC_OPC        6'h0B
`define DSJX_DEST_BIT       5
`define DSJX_FADDR_HI       4
`define DSJX_FADDR_LO       0
`define DSJX_JMP_OPC_HI     11
`define DSJX_JMP_OPC_LO     9
`define DSJX_JMP_OPC        3'h5
`define DSJX_LIT_HI         8
`define DSJX_LIT_LO         0
`define DSJX_PAGE_HI        6
`define DSJX_PAGE_LO        5
`define DSJX_DEST_W         1'h0
`define DSJX_DEST_F         1'h1
`define DSJX_DEC_STEP       8'h01
`define DSJX_PC_STEP        11'h001
`define DSJX_PC_RST         11'h000
`define DSJX_ZERO_DATA      8'h00

`endif

/* File: hw/dsjx_pkg.sv */
/*
 * types and opcode decode functions shared by the execution block and its
 * arithmetic helper. assumes dsjx_regs.svh is on the include path.
 */
`include "dsjx_regs.svh"

package dsjx_pkg;

    typedef struct packed {
        logic                       we;
        logic [`DSJX_FADDR_W-1:0]   addr;
        logic [`DSJX_DATA_W-1:0]    data;
    } dsjx_rf_wr_t;

    typedef struct packed {
        logic                       we;
        logic [`DSJX_DATA_W-1:0]    data;
    } dsjx_w_wr_t;

    typedef enum logic [0:0] {
        DSJX_EXEC    = 1'h0,
        DSJX_DISCARD = 1'h1
    } dsjx_state_t;

    function automatic logic dsjx_is_dec_skip(input logic [`DSJX_INSTR_W-1:0] instr);
        return instr[`DSJX_DEC_OPC_HI:`DSJX_DEC_OPC_LO] == `DSJX_DEC_OPC;
    endfunction : dsjx_is_dec_skip

    function automatic logic dsjx_is_jump(input logic [`DSJX_INSTR_W-1:0] instr);
        return instr[`DSJX_JMP_OPC_HI:`DSJX_JMP_OPC_LO] == `DSJX_JMP_OPC;
    endfunction : dsjx_is_jump

endpackage : dsjx_pkg

/* File: hw/dsjx_alu.sv */
/*
 * combinational helper: decrement of the operand with zero detect, and the
 * direct jump target built from the literal and the page-select bits.
 * assumes operand and status are stable for the whole instruction cycle.
 */
`timescale 1ns/1ps
`include "dsjx_regs.svh"

module dsjx_alu (
    input  wire logic [`DSJX_DATA_W-1:0]  oper,
    input  wire logic [`DSJX_INSTR_W-1:0] instr,
    input  wire logic [`DSJX_DATA_W-1:0]  status,
    output logic      [`DSJX_DATA_W-1:0]  dec_res,
    output logic                          dec_zero,
    output logic      [`DSJX_PC_W-1:0]    jump_target
);
    import dsjx_pkg::*;

    always_comb begin
        dec_res     = oper - `DSJX_DEC_STEP;
        dec_zero    = (dec_res == `DSJX_ZERO_DATA);
        jump_target = {status[`DSJX_PAGE_HI:`DSJX_PAGE_LO],
                       instr[`DSJX_LIT_HI:`DSJX_LIT_LO]};
    end

endmodule : dsjx_alu

/* File: hw/dsjx_exec.sv */
/*
 * execution of the decrement-skip-if-zero and direct jump instructions.
 * each clock is one instruction cycle: INSTR holds the fetched word, OPER the
 * contents of the data register it addresses, STATUS the status register.
 * other opcodes only advance the program counter here; the rest of the core
 * executes them. status flags are never written by this block.
 */
// Functional notes
// - decrement-skip result is the addressed register minus one.
// - destination bit 0 writes working register, 1 writes the data register.
// - zero result discards the fetched next instruction, executing a nop instead.
// - direct jump loads its 9-bit literal into program counter bits 8..0.
// - direct jump loads counter bits 10..9 from status bits 6..5.
// - direct jump occupies one word and takes two cycles.
// - jump recognised by leading opcode bits 101; status flags untouched.
`timescale 1ns/1ps
`include "dsjx_regs.svh"

module dsjx_exec (
    input  wire logic                          CLK_SYS,
    input  wire logic                          SRST,
    input  wire logic [`DSJX_INSTR_W-1:0]      INSTR,
    input  wire logic [`DSJX_DATA_W-1:0]       OPER,
    input  wire logic [`DSJX_DATA_W-1:0]       STATUS,
    output logic      [`DSJX_PC_W-1:0]         PROGRAM_COUNTER,
    output dsjx_pkg::dsjx_rf_wr_t              RF_WR,
    output dsjx_pkg::dsjx_w_wr_t               W_WR,
    output logic                               DISCARD,
    output logic                               JUMP_TAKEN
);
    import dsjx_pkg::*;

    dsjx_state_t                state_ff;
    dsjx_state_t                nxt_state;
    logic [`DSJX_PC_W-1:0]      pc_ff;
    logic [`DSJX_PC_W-1:0]      nxt_pc;
    dsjx_rf_wr_t                rf_wr_ff;
    dsjx_rf_wr_t                nxt_rf_wr;
    dsjx_w_wr_t                 w_wr_ff;
    dsjx_w_wr_t                 nxt_w_wr;
    logic                       jump_ff;
    logic                       nxt_jump;
    logic                       discard_ff;
    logic                       nxt_discard;
    logic [`DSJX_DATA_W-1:0]    dec_res;
    logic                       dec_zero;
    logic [`DSJX_PC_W-1:0]      jump_target;
    logic                       exec_dec;
    logic                       exec_jump;

    dsjx_alu u_alu (
        .oper        (OPER),
        .instr       (INSTR),
        .status      (STATUS),
        .dec_res     (dec_res),
        .dec_zero    (dec_zero),
        .jump_target (jump_target)
    );

    // in the discard slot the fetched word is never executed
    assign exec_dec  = (state_ff == DSJX_EXEC) && dsjx_is_dec_skip(INSTR);
    assign exec_jump = (state_ff == DSJX_EXEC) && dsjx_is_jump(INSTR);

    // the counter steps on every cycle that is not a jump, the discard slot too,
    // so a skipped word is passed over and never fetched a second time
    always_comb begin
        nxt_state     = DSJX_EXEC;
        nxt_pc        = pc_ff + `DSJX_PC_STEP;
        nxt_rf_wr     = '0;
        nxt_w_wr      = '0;
        nxt_jump      = 1'b0;
        unique case (state_ff)
            DSJX_EXEC: begin
                if (exec_dec) begin
                    if (INSTR[`DSJX_DEST_BIT] == `DSJX_DEST_F) begin
                        nxt_rf_wr.we   = 1'b1;
                        nxt_rf_wr.addr = INSTR[`DSJX_FADDR_HI:`DSJX_FADDR_LO];
                        nxt_rf_wr.data = dec_res;
                    end else begin
                        nxt_w_wr.we    = 1'b1;
                        nxt_w_wr.data  = dec_res;
                    end
                    if (dec_zero) begin
                        nxt_state = DSJX_DISCARD;
                    end
                end else if (exec_jump) begin
                    nxt_pc    = jump_target;
                    nxt_jump  = 1'b1;
                    nxt_state = DSJX_DISCARD;
                end
            end
            DSJX_DISCARD: begin
                nxt_state = DSJX_EXEC;
            end
        endcase
        nxt_discard = (nxt_state == DSJX_DISCARD);
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_ff <= DSJX_EXEC;
            pc_ff    <= `DSJX_PC_RST;
            rf_wr_ff <= '0;
            w_wr_ff  <= '0;
            jump_ff  <= 1'b0;
            discard_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pc_ff    <= nxt_pc;
            rf_wr_ff <= nxt_rf_wr;
            w_wr_ff  <= nxt_w_wr;
            jump_ff  <= nxt_jump;
            discard_ff <= nxt_discard;
        end
    end

    assign PROGRAM_COUNTER = pc_ff;
    assign RF_WR           = rf_wr_ff;
    assign W_WR            = w_wr_ff;
    assign DISCARD         = discard_ff;
    assign JUMP_TAKEN      = jump_ff;

    // outputs are checked one cycle after the executing edge; the word they
    // answer to is read back through $past
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    property p_dec_value;
        (state_ff == DSJX_EXEC) && dsjx_is_dec_skip(INSTR) |=>
            (RF_WR.we ? RF_WR.data : W_WR.data) == $past(OPER) - `DSJX_DEC_STEP;
    endproperty
    a_dec_value: assert property (p_dec_value) else $error("decrement value wrong");

    property p_dest;
        (state_ff == DSJX_EXEC) && dsjx_is_dec_skip(INSTR) |=>
            (RF_WR.we == $past(INSTR[`DSJX_DEST_BIT])) && (W_WR.we != RF_WR.we)
            && (!RF_WR.we || RF_WR.addr == $past(INSTR[`DSJX_FADDR_HI:`DSJX_FADDR_LO]));
    endproperty
    a_dest: assert property (p_dest) else $error("decrement destination wrong");

    property p_skip;
        (state_ff == DSJX_EXEC) && dsjx_is_dec_skip(INSTR) |=>
            DISCARD == (($past(OPER) - `DSJX_DEC_STEP) == `DSJX_ZERO_DATA);
    endproperty
    a_skip: assert property (p_skip) else $error("skip slot not discarded");

    property p_jump_low;
        (state_ff == DSJX_EXEC) && dsjx_is_jump(INSTR) |=>
            PROGRAM_COUNTER[`DSJX_LIT_HI:`DSJX_LIT_LO] ==
                $past(INSTR[`DSJX_LIT_HI:`DSJX_LIT_LO]);
    endproperty
    a_jump_low: assert property (p_jump_low) else $error("jump literal not loaded");

    property p_jump_page;
        (state_ff == DSJX_EXEC) && dsjx_is_jump(INSTR) |=>
            PROGRAM_COUNTER[`DSJX_PC_W-1:`DSJX_LIT_HI+1] ==
                $past(STATUS[`DSJX_PAGE_HI:`DSJX_PAGE_LO]);
    endproperty
    a_jump_page: assert property (p_jump_page) else $error("page bits not loaded");

    property p_jump_two;
        JUMP_TAKEN |-> DISCARD ##1 !DISCARD && !JUMP_TAKEN;
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

    property p_jump_decode;
        $rose(JUMP_TAKEN) || (JUMP_TAKEN && !$past(JUMP_TAKEN)) |->
            $past(INSTR[`DSJX_JMP_OPC_HI:`DSJX_JMP_OPC_LO]) == `DSJX_JMP_OPC
            && !RF_WR.we && !W_WR.we;
    endproperty
    a_jump_decode: assert property (p_jump_decode) else $error("jump decode wrong");

    property p_skip_advance;
        DISCARD && !JUMP_TAKEN |=>
            PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + `DSJX_PC_STEP;
    endproperty
    a_skip_advance: assert property (p_skip_advance) else $error("counter stalled");

    // reset is checked with the default disable switched off
    property p_reset_values;
        disable iff (1'h0)
        SRST |=>
            (PROGRAM_COUNTER == `DSJX_PC_RST) && !DISCARD && !JUMP_TAKEN
            && !RF_WR.we && !W_WR.we;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset state wrong");

    property p_discard_quiet;
        DISCARD |=> !DISCARD && !RF_WR.we && !W_WR.we && !JUMP_TAKEN;
    endproperty
    a_discard_quiet: assert property (p_discard_quiet) else $error("discard slot active");

    property p_discard_cause;
        DISCARD |->
            ($past(state_ff) == DSJX_EXEC)
            && (($past(INSTR[`DSJX_JMP_OPC_HI:`DSJX_JMP_OPC_LO]) == `DSJX_JMP_OPC)
                || (($past(INSTR[`DSJX_DEC_OPC_HI:`DSJX_DEC_OPC_LO]) == `DSJX_DEC_OPC)
                    && (($past(OPER) - `DSJX_DEC_STEP) == `DSJX_ZERO_DATA)));
    endproperty
    a_discard_cause: assert property (p_discard_cause) else $error("stray discard");

    property p_other_advance;
        (state_ff == DSJX_EXEC) && !dsjx_is_dec_skip(INSTR) && !dsjx_is_jump(INSTR) |=>
            (PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + `DSJX_PC_STEP)
            && !DISCARD && !JUMP_TAKEN && !RF_WR.we && !W_WR.we;
    endproperty
    a_other_advance: assert property (p_other_advance) else $error("opcode misdecoded");

    property p_dec_advance;
        (state_ff == DSJX_EXEC) && dsjx_is_dec_skip(INSTR) |=>
            (PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + `DSJX_PC_STEP) && !JUMP_TAKEN;
    endproperty
    a_dec_advance: assert property (p_dec_advance) else $error("decrement moved counter");

    property p_jump_enter;
        (state_ff == DSJX_EXEC) && dsjx_is_jump(INSTR) |=>
            JUMP_TAKEN && DISCARD && !RF_WR.we && !W_WR.we;
    endproperty
    a_jump_enter: assert property (p_jump_enter) else $error("jump not taken");

    property p_jump_resume;
        JUMP_TAKEN |=> PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + `DSJX_PC_STEP;
    endproperty
    a_jump_resume: assert property (p_jump_resume) else $error("jump did not resume");

    property p_write_source;
        RF_WR.we || W_WR.we |->
            ($past(state_ff) == DSJX_EXEC)
            && ($past(INSTR[`DSJX_DEC_OPC_HI:`DSJX_DEC_OPC_LO]) == `DSJX_DEC_OPC)
            && (RF_WR.we == $past(INSTR[`DSJX_DEST_BIT]));
    endproperty
    a_write_source: assert property (p_write_source) else $error("stray write");

endmodule : dsjx_exec

/* File: bench/test_decrement_skip_and_jump_exec.sv */
/*
 * self-checking bench for the decrement-skip / direct-jump execution block.
 * assumes dsjx_regs.svh on the include path and dsjx_pkg compiled first.
 */
`timescale 1ns/1ps
`include "dsjx_regs.svh"

module test_decrement_skip_and_jump_exec;
    import dsjx_pkg::*;

    typedef struct packed {
        logic [10:0] pc;
        logic        disc;
        logic        jt;
        logic        rf_we;
        logic [12:0] rf;
        logic        w_we;
        logic [7:0]  w;
    } dsjx_exp_t;

    logic        clk_sys    = 1'b0;
    logic        srst       = 1'b1;
    logic [11:0] instr      = 12'h000;
    logic [7:0]  oper       = 8'h00;
    logic [7:0]  status     = 8'h00;
    logic [10:0] pc;
    dsjx_rf_wr_t rf_wr;
    dsjx_w_wr_t  w_wr;
    logic        discard;
    logic        jump_taken;
    dsjx_exp_t   exp_q[$];
    dsjx_exp_t   got;
    int          fail_count = 0;
    int          tests_run  = 0;
    int          seed       = 46;
    logic [10:0] pc_m       = 11'h000;
    logic        disc_m     = 1'b0;
    logic [31:0] rnd;

    always #5 clk_sys = ~clk_sys;

    dsjx_exec u_dut (
        .CLK_SYS         (clk_sys),
        .SRST            (srst),
        .INSTR           (instr),
        .OPER            (oper),
        .STATUS          (status),
        .PROGRAM_COUNTER (pc),
        .RF_WR           (rf_wr),
        .W_WR            (w_wr),
        .DISCARD         (discard),
        .JUMP_TAKEN      (jump_taken)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD t=%0t got %h want %h", $time, seen, want);
        end
    endtask : check

    // drives one instruction cycle and notes what the following edge must show
    task automatic step(input logic rst, input logic [11:0] i, input logic [7:0] o,
                        input logic [7:0] s);
        dsjx_exp_t e;
        logic [7:0] r;
        @(negedge clk_sys);
        srst = rst;
        instr = i;
        oper = o;
        status = s;
        e = '0;
        r = o - 8'h01;
        if (rst) begin
            pc_m = 11'h000;
            disc_m = 1'b0;
        end else if (disc_m) begin
            pc_m = pc_m + 11'h001;
            disc_m = 1'b0;
        end else if (i[11:6] == 6'h0B) begin
            e.rf_we = i[5];
            e.rf = {i[4:0], r};
            e.w_we = ~i[5];
            e.w = r;
            disc_m = (r == 8'h00);
            pc_m = pc_m + 11'h001;
        end else if (i[11:9] == 3'h5) begin
            pc_m = {s[6:5], i[8:0]};
            disc_m = 1'b1;
            e.jt = 1'b1;
        end else begin
            pc_m = pc_m + 11'h001;
        end
        e.pc = pc_m;
        e.disc = disc_m;
        exp_q.push_back(e);
    endtask : step

    always @(posedge clk_sys) begin
        #1;
        if (exp_q.size() > 0) begin
            got = exp_q.pop_front();
            check(16'(pc), 16'(got.pc));
            check(16'(discard), 16'(got.disc));
            check(16'(jump_taken), 16'(got.jt));
            check(16'(rf_wr.we), 16'(got.rf_we));
            if (got.rf_we) check(16'({rf_wr.addr, rf_wr.data}), 16'(got.rf));
            check(16'(w_wr.we), 16'(got.w_we));
            if (got.w_we) check(16'(w_wr.data), 16'(got.w));
        end
    end

    task automatic test_done();
        @(posedge clk_sys);
        #2;
        if (exp_q.size() != 0) fail_count++;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5) step(1'b1, 12'h000, 8'h00, 8'h00);
        // skip whose discarded word is a jump, then a skip discarding another skip
        step(1'b0, 12'h2E3, 8'h01, 8'h00);
        step(1'b0, 12'hB23, 8'h00, 8'h60);
        step(1'b0, 12'h2C5, 8'h05, 8'h00);
        step(1'b0, 12'h2DF, 8'h00, 8'h00);
        step(1'b0, 12'h2FF, 8'h01, 8'h00);
        step(1'b0, 12'h2C0, 8'h01, 8'h00);
        $display("test skip done");
        // every page, boundary literals, a second jump in the discard cycle
        for (int p = 0; p < 4; p++) begin
            step(1'b0, p[0] ? 12'hBFF : 12'hA00, 8'h00, {1'b1, p[1:0], 5'h1F});
            step(1'b0, 12'hA55, 8'h00, 8'h00);
        end
        $display("test jump done");
        // neighbouring opcodes only advance the counter
        step(1'b0, 12'h0C1, 8'h01, 8'h00);
        step(1'b0, 12'h3C1, 8'hFF, 8'h00);
        step(1'b0, 12'h2A1, 8'h01, 8'h00);
        step(1'b0, 12'h400, 8'h01, 8'h60);
        step(1'b0, 12'hE00, 8'h01, 8'h60);
        $display("test other done");
        // random mix with a reset in mid-run
        for (int n = 0; n < 300; n++) begin
            rnd = $random(seed);
            step(n == 150, n[0] ? {6'h0B, rnd[5:0]} : rnd[11:0],
                 rnd[30] ? {6'h00, rnd[13:12]} : rnd[27:20], rnd[31:24]);
        end
        $display("test random done");
        test_done();
    end

endmodule : test_decrement_skip_and_jump_exec
